/* gpe_top.sv */
// General-purpose event logic: group0 enables and status, input events.
// Assumes synchronous pins and an I/O decoder giving offset strobes.
`timescale 1ns/1ps
module gpe_top
  import gpe_pkg::*;
#(
  parameter int N_IN = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic thermal_alert_pin,
  input wire logic mgmt_event_set,
  input wire logic audio_codec_set,
  input wire logic second_usb_set,
  input wire logic first_usb_set,
  input wire logic [N_IN-1:0] gpio_pin,
  input wire logic [N_IN-1:0] gpio_is_input,
  input wire logic [N_IN-1:0] input_level_invert,
  input wire logic [N_IN-1:0] input_event_enable,
  input wire logic [2*N_IN-1:0] input_event_route,
  input wire logic sleeping,
  input wire logic sci_select,
  output logic sci,
  output logic smi,
  output logic wake
);
  logic [15:0] event_group0_enable_r;
  logic [15:0] event_group0_enable_nxt;
  logic [15:0] io_rdata_r;
  logic [15:0] io_rdata_nxt;
  logic sci_r;
  logic smi_r;
  logic wake_r;
  logic [15:0] g0_sts;
  logic [15:0] g0_set;
  logic [N_IN-1:0] input_event_status;
  logic [N_IN-1:0] in_active;
  logic [N_IN-1:0] in_route_smi;
  logic [N_IN-1:0] in_route_sci;

  wire wr_g0_en = io_wr && (io_addr == GPE_OFS_G0_ENABLE);
  wire wr_g0_sts = io_wr && (io_addr == GPE_OFS_G0_STATUS);
  wire wr_in_sts = io_wr && (io_addr == GPE_OFS_IN_STATUS);

  wire mgmt_event_irq_enable = event_group0_enable_r[GPE_BIT_MGMT];
  wire audio_codec_wake_enable = event_group0_enable_r[GPE_BIT_AUDIO];
  wire second_usb_wake_enable = event_group0_enable_r[GPE_BIT_USB2];
  wire first_usb_wake_enable = event_group0_enable_r[GPE_BIT_USB1];
  wire thermal_pin_polarity = event_group0_enable_r[GPE_BIT_POL];
  wire thermal_report_enable = event_group0_enable_r[GPE_BIT_THERM];

  wire mgmt_event_irq_flag = g0_sts[GPE_BIT_MGMT];
  wire audio_codec_wake_flag = g0_sts[GPE_BIT_AUDIO];
  wire second_usb_wake_flag = g0_sts[GPE_BIT_USB2];
  wire first_usb_wake_flag = g0_sts[GPE_BIT_USB1];
  wire thermal_event_flag = g0_sts[GPE_BIT_THERM];

  // Thermal pin counts as active at the level the polarity bit names
  wire thermal_active = (thermal_alert_pin == thermal_pin_polarity);
  wire thermal_pme = thermal_event_flag & thermal_report_enable;

  always_comb begin
    g0_set = 16'h0000;
    g0_set[GPE_BIT_MGMT] = mgmt_event_set;
    g0_set[GPE_BIT_AUDIO] = audio_codec_set;
    g0_set[GPE_BIT_USB2] = second_usb_set;
    g0_set[GPE_BIT_USB1] = first_usb_set;
    g0_set[GPE_BIT_THERM] = thermal_active;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_g0
      if (GPE_G0_STATUS_MASK[gi]) begin : g_impl
        gpe_flag #(.RESET_VAL(GPE_RESET_VAL[gi])) u_flag (
          .clk(core_clk),
          .rst(rst),
          .set(g0_set[gi]),
          .clr(wr_g0_sts & io_wdata[gi]),
          .flag(g0_sts[gi])
        );
      end else begin : g_none
        assign g0_sts[gi] = 1'b0;
      end
    end
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      // Active when input and low, or high with inversion set
      assign in_active[gi] = gpio_is_input[gi] &
        ~(gpio_pin[gi] ^ input_level_invert[gi]);
      assign in_route_smi[gi] =
        (input_event_route[2*gi+:2] == GPE_ROUTE_SMI);
      assign in_route_sci[gi] =
        (input_event_route[2*gi+:2] == GPE_ROUTE_SCI);
      if (GPE_IN_STATUS_MASK[gi]) begin : g_impl
        gpe_flag #(.RESET_VAL(GPE_RESET_VAL[gi])) u_flag (
          .clk(core_clk),
          .rst(rst),
          .set(in_active[gi]),
          .clr(wr_in_sts & io_wdata[gi]),
          .flag(input_event_status[gi])
        );
      end else begin : g_none
        assign input_event_status[gi] = 1'b0;
      end
    end
  endgenerate

  wire [N_IN-1:0] in_pending = input_event_status & input_event_enable;
  wire in_wake = |in_pending;
  wire in_smi = |(in_pending & in_route_smi);
  wire in_sci = |(in_pending & in_route_sci);

  wire sci_nxt = (mgmt_event_irq_flag & mgmt_event_irq_enable) |
    (thermal_pme & sci_select) |
    (in_sci & ~sleeping);
  wire smi_nxt = (thermal_pme & ~sci_select) |
    (in_smi & ~sleeping);
  wire wake_nxt = sleeping & (
    (audio_codec_wake_flag & audio_codec_wake_enable) |
    (second_usb_wake_flag & second_usb_wake_enable) |
    (first_usb_wake_flag & first_usb_wake_enable) |
    in_wake);

  assign event_group0_enable_nxt = wr_g0_en ?
    (io_wdata & GPE_G0_ENABLE_MASK) : event_group0_enable_r;

  wire [15:0] in_sts_word = 16'(input_event_status) & GPE_IN_STATUS_MASK;
  assign io_rdata_nxt = !io_rd ? 16'h0000 :
    (io_addr == GPE_OFS_G0_ENABLE) ? event_group0_enable_r :
    (io_addr == GPE_OFS_G0_STATUS) ? g0_sts :
    (io_addr == GPE_OFS_IN_STATUS) ? in_sts_word : 16'h0000;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_group0_enable_r <= GPE_RESET_VAL;
      io_rdata_r <= 16'h0000;
      sci_r <= 1'b0;
      smi_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      event_group0_enable_r <= event_group0_enable_nxt;
      io_rdata_r <= io_rdata_nxt;
      sci_r <= sci_nxt;
      smi_r <= smi_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign io_rdata = io_rdata_r;
  assign sci = sci_r;
  assign smi = smi_r;
  assign wake = wake_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_in_clear_idle;
    wr_in_sts && io_wdata[0] && !in_active[0];
  endsequence
  sequence s_in_cleared;
    !input_event_status[0];
  endsequence
  sequence s_therm_clear_idle;
    wr_g0_sts && io_wdata[GPE_BIT_THERM] && !thermal_active;
  endsequence

  AST_MGMT_SCI: assert property (
    mgmt_event_irq_flag && mgmt_event_irq_enable |=> sci_r)
    else $error("management flag did not raise sci");
  AST_AUDIO_WAKE: assert property (
    sleeping && audio_codec_wake_flag && audio_codec_wake_enable |=> wake_r)
    else $error("audio flag did not wake");
  AST_USB2_WAKE: assert property (
    sleeping && second_usb_wake_flag && second_usb_wake_enable |=> wake_r)
    else $error("second usb flag did not wake");
  AST_USB1_WAKE: assert property (
    sleeping && first_usb_wake_flag && first_usb_wake_enable |=> wake_r)
    else $error("first usb flag did not wake");
  AST_THERM_SET: assert property (
    thermal_alert_pin == thermal_pin_polarity |=> thermal_event_flag)
    else $error("thermal flag not set at active level");
  AST_THERM_SCI: assert property (
    thermal_pme && sci_select |=> sci_r)
    else $error("thermal event did not raise sci");
  AST_THERM_SMI: assert property (
    thermal_pme && !sci_select |=> smi_r)
    else $error("thermal event did not raise smi");
  AST_THERM_CLR: assert property (
    s_therm_clear_idle |=> !thermal_event_flag)
    else $error("write one did not clear thermal flag");
  AST_MGMT_OFF: assert property (
    !mgmt_event_irq_enable && !thermal_pme && !(in_sci && !sleeping)
    |=> !sci_r)
    else $error("sci raised with no enabled source");
  AST_IN_SET: assert property (
    gpio_is_input[0] && !(gpio_pin[0] ^ input_level_invert[0])
    |=> input_event_status[0])
    else $error("input status not set");
  AST_IN_CLEAR: assert property (
    s_in_clear_idle |=> s_in_cleared)
    else $error("write one did not clear input status");
  AST_IN_HOLD: assert property (
    input_event_status[0] && in_active[0] |=> input_event_status[0])
    else $error("status cleared while pin active");
  AST_IN_WAKE: assert property (
    sleeping && in_wake |=> wake_r)
    else $error("enabled input did not wake");
  AST_IN_ROUTE: assert property (
    !sleeping && in_smi |=> smi_r)
    else $error("routed input did not raise smi");
  AST_IN_SCI: assert property (
    !sleeping && in_sci |=> sci_r)
    else $error("routed input did not raise sci");
  AST_WAKE_AWAKE: assert property (
    !sleeping |=> !wake_r)
    else $error("wake raised in working state");
  AST_EN_RSVD: assert property (
    io_rd && io_addr == GPE_OFS_G0_ENABLE |=> !io_rdata_r[1] &&
    io_rdata_r[15:7] == 9'h000)
    else $error("reserved enable bit read nonzero");
  AST_RSVD: assert property (
    io_rd && io_addr == GPE_OFS_IN_STATUS |=> !io_rdata_r[5] && !io_rdata_r[2])
    else $error("absent input status bit read nonzero");
endmodule

/* gpe_pkg.sv */
// Constants for the general-purpose event logic: offsets, masks, fields.
// Assumes an I/O decoder that hands over the offset from the I/O base.
// Function
// - Management flag and enable raise SCI
// - Audio codec flag wakes when enabled
// - Second USB flag wakes when enabled
// - First USB flag wakes when enabled
// - Polarity picks thermal pin active level
// - Enabled thermal assertion raises SCI or SMI
// - Active input pin sets its status bit
// - Writing one clears status, zero keeps
// - Status cannot clear while pin active
// - Enabled input status wakes sleeping system
// - Enabled status in working state routes SMI/SCI
// - Input status bits 5, 2 absent
// - Thermal flag set by hardware, write-one clears
package gpe_pkg;
  localparam logic [7:0] GPE_OFS_G0_STATUS = 8'h28;
  localparam logic [7:0] GPE_OFS_G0_ENABLE = 8'h2A;
  localparam logic [7:0] GPE_OFS_IN_STATUS = 8'h2C;
  localparam logic [15:0] GPE_G0_ENABLE_MASK = 16'h007D;
  localparam logic [15:0] GPE_G0_STATUS_MASK = 16'h0079;
  localparam logic [15:0] GPE_IN_STATUS_MASK = 16'hFFDB;
  localparam logic [15:0] GPE_RESET_VAL = 16'h0000;
  localparam int GPE_BIT_MGMT = 6;
  localparam int GPE_BIT_AUDIO = 5;
  localparam int GPE_BIT_USB2 = 4;
  localparam int GPE_BIT_USB1 = 3;
  localparam int GPE_BIT_POL = 2;
  localparam int GPE_BIT_THERM = 0;
  localparam logic [1:0] GPE_ROUTE_SMI = 2'h1;
  localparam logic [1:0] GPE_ROUTE_SCI = 2'h2;
endpackage

/* gpe_flag.sv */
// One sticky status flag with write-one-to-clear.
// Assumes set and clear are synchronous to the clock.
`timescale 1ns/1ps
module gpe_flag
  import gpe_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  logic flag_r;
  logic flag_nxt;
  // Set wins over clear, so a still active source keeps the flag
  assign flag_nxt = set | (flag_r & ~clr);
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= RESET_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag = flag_r;
endmodule

/* tb_top.sv */
// Self-checking bench for the general-purpose event logic top.
// Assumes the design holds its own assertions; drives all ports directly.
`timescale 1ns/1ps
module tb_top;
  import gpe_pkg::*;
  logic core_clk = 0, rst = 1, io_rd = 0, io_wr = 0, sleeping = 0;
  logic [7:0] io_addr = 8'h00;
  logic [15:0] io_wdata = 16'h0000, gpio_pin = 16'hFFFF;
  logic [15:0] is_in = 16'hFFFF, inv = 16'h0000, ien = 16'h0000;
  logic [31:0] route = 32'h0;
  logic therm = 1, mgmt = 0, usb2 = 0, usb1 = 0, sci_sel = 0, audio = 0;
  logic [15:0] io_rdata;
  logic sci, smi, wake;
  int fails = 0, checked = 0, cyc = 0;
  gpe_top dut (.core_clk(core_clk), .rst(rst), .io_rd(io_rd),
    .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .thermal_alert_pin(therm),
    .mgmt_event_set(mgmt), .audio_codec_set(audio),
    .second_usb_set(usb2), .first_usb_set(usb1), .gpio_pin(gpio_pin),
    .gpio_is_input(is_in), .input_level_invert(inv),
    .input_event_enable(ien), .input_event_route(route),
    .sleeping(sleeping), .sci_select(sci_sel), .sci(sci), .smi(smi),
    .wake(wake));
  always #12.5 core_clk = ~core_clk;
  task automatic complete_run();
    $display("Counts: checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    io_wr <= 1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge core_clk);
    io_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                    input string msg);
    @(posedge core_clk);
    io_rd <= 1;
    io_addr <= a;
    @(posedge core_clk);
    io_rd <= 0;
    #1;
    chk(io_rdata, exp, msg);
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic t_regs();
    rd(GPE_OFS_G0_ENABLE, 16'h0000, "enable reset");
    wr(GPE_OFS_G0_ENABLE, 16'hFFFF);
    rd(GPE_OFS_G0_ENABLE, 16'h007D, "enable mask");
    rd(8'h40, 16'h0000, "unmapped read");
    wr(GPE_OFS_G0_ENABLE, 16'h0000);
    wr(GPE_OFS_G0_STATUS, 16'hFFFF);
    $display("test regs done");
  endtask
  task automatic t_mgmt();
    wr(GPE_OFS_G0_ENABLE, 16'h0040);
    @(posedge core_clk) mgmt <= 1;
    @(posedge core_clk) mgmt <= 0;
    settle();
    chk(sci, 1'b1, "mgmt sci");
    wr(GPE_OFS_G0_ENABLE, 16'h0000);
    settle();
    chk(sci, 1'b0, "mgmt sci off");
    wr(GPE_OFS_G0_STATUS, 16'h0040);
    $display("test mgmt done");
  endtask
  task automatic t_usb();
    sleeping <= 1;
    wr(GPE_OFS_G0_ENABLE, 16'h0008);
    @(posedge core_clk) begin usb1 <= 1; usb2 <= 1; audio <= 1; end
    @(posedge core_clk) begin usb1 <= 0; usb2 <= 0; audio <= 0; end
    settle();
    chk(wake, 1'b1, "usb1 wake");
    wr(GPE_OFS_G0_STATUS, 16'h0008);
    settle();
    chk(wake, 1'b0, "usb2 disabled");
    rd(GPE_OFS_G0_STATUS, 16'h0030, "usb2 flag");
    wr(GPE_OFS_G0_ENABLE, 16'h0010);
    settle();
    chk(wake, 1'b1, "usb2 wake");
    wr(GPE_OFS_G0_STATUS, 16'h0010);
    settle();
    chk(wake, 1'b0, "audio disabled");
    wr(GPE_OFS_G0_ENABLE, 16'h0020);
    settle();
    chk(wake, 1'b1, "audio wake");
    wr(GPE_OFS_G0_STATUS, 16'h0020);
    sleeping <= 0;
    $display("test usb done");
  endtask
  task automatic t_therm();
    sci_sel <= 1;
    wr(GPE_OFS_G0_ENABLE, 16'h0005);
    settle();
    chk(sci, 1'b1, "thermal sci");
    chk(smi, 1'b0, "thermal no smi");
    rd(GPE_OFS_G0_STATUS, 16'h0001, "thermal flag");
    @(posedge core_clk) therm <= 0;
    wr(GPE_OFS_G0_STATUS, 16'h0001);
    rd(GPE_OFS_G0_STATUS, 16'h0000, "thermal clear");
    @(posedge core_clk) sci_sel <= 0;
    wr(GPE_OFS_G0_ENABLE, 16'h0001);
    settle();
    chk(smi, 1'b1, "thermal smi");
    rd(GPE_OFS_G0_STATUS, 16'h0001, "low level sets");
    @(posedge core_clk) therm <= 1;
    wr(GPE_OFS_G0_ENABLE, 16'h0000);
    wr(GPE_OFS_G0_STATUS, 16'h0001);
    rd(GPE_OFS_G0_STATUS, 16'h0000, "thermal idle");
    $display("test thermal done");
  endtask
  task automatic t_gpi();
    @(posedge core_clk) begin
      gpio_pin <= 16'hFD5B;
      is_in <= 16'hFDFF;
      inv <= 16'h0100;
    end
    settle();
    rd(GPE_OFS_IN_STATUS, 16'h0180, "input set");
    wr(GPE_OFS_IN_STATUS, 16'hFFFF);
    rd(GPE_OFS_IN_STATUS, 16'h0180, "clear while active");
    @(posedge core_clk) begin
      gpio_pin <= 16'hFFFF;
      is_in <= 16'hFFFF;
      inv <= 16'h0000;
    end
    wr(GPE_OFS_IN_STATUS, 16'h0080);
    rd(GPE_OFS_IN_STATUS, 16'h0100, "write one clears");
    @(posedge core_clk) begin
      ien <= 16'h0100;
      route[17:16] <= GPE_ROUTE_SMI;
      sleeping <= 1;
    end
    settle();
    chk(wake, 1'b1, "input wake");
    chk(smi, 1'b0, "no smi asleep");
    @(posedge core_clk) sleeping <= 0;
    settle();
    chk(smi, 1'b1, "input smi");
    chk(wake, 1'b0, "no wake awake");
    @(posedge core_clk) route[17:16] <= GPE_ROUTE_SCI;
    settle();
    chk(sci, 1'b1, "input sci");
    chk(smi, 1'b0, "smi follows route");
    wr(GPE_OFS_IN_STATUS, 16'hFFFF);
    rd(GPE_OFS_IN_STATUS, 16'h0000, "absent bits zero");
    $display("test inputs done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    t_regs();
    t_mgmt();
    t_usb();
    t_therm();
    t_gpi();
    complete_run();
  end
endmodule
